// ==== src/apc_chain.sv ====
// angle post-processing chain with apb configuration
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module apc_chain #(
  parameter int MAX_POINTS = 33
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] angle_in,
  input wire logic angle_in_valid,
  output logic [15:0] angle_out,
  output logic angle_out_valid,
  output logic clamp_flag
);
  // table and index widths serve at most 33 points
  if (MAX_POINTS < 2 || MAX_POINTS > 33) begin : g_chk
    $error("MAX_POINTS must lie in 2..33");
  end

  // configuration registers
  logic [13:0] ctrl_r, ctrl_nxt;
  logic [14:0] zero_point_shift_r, zero_point_shift_nxt;
  logic [23:0] limits_r, limits_nxt;
  logic [15:0] angle_scale_factor_r, angle_scale_factor_nxt;
  logic [15:0] late_angle_shift_r, late_angle_shift_nxt;
  logic flag_sticky_r, flag_sticky_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [12:0] point_r [MAX_POINTS];

  // datapath registers
  logic [15:0] s1_angle_r, s1_angle_nxt;
  logic s1_valid_r, s1_valid_nxt;
  logic s1_flag_r, s1_flag_nxt;
  logic [15:0] out_angle_r, out_angle_nxt;
  logic out_valid_r, out_valid_nxt;
  logic out_flag_r, out_flag_nxt;

  // decoded fields
  logic limit_compare_enable;
  logic scale_clamp_enable;
  logic late_shift_clamp_enable;
  logic rotation_direction_invert;
  logic [1:0] curve_mode;
  logic [1:0] correction_range_select;
  logic [5:0] point_count;
  logic [7:0] lower_angle_limit;
  logic [7:0] upper_angle_limit;
  logic [7:0] clamp_wrap_point;

  assign limit_compare_enable = ctrl_r[apc_pkg::CTRL_LIMIT_EN];
  assign scale_clamp_enable = ctrl_r[apc_pkg::CTRL_SCALE_CLAMP];
  assign late_shift_clamp_enable = ctrl_r[apc_pkg::CTRL_LATE_CLAMP];
  assign rotation_direction_invert = ctrl_r[apc_pkg::CTRL_DIR_INV];
  assign curve_mode = ctrl_r[apc_pkg::CTRL_MODE_LO +: 2];
  assign correction_range_select = ctrl_r[apc_pkg::CTRL_RANGE_LO +: 2];
  assign point_count = ctrl_r[apc_pkg::CTRL_CNT_LO +: apc_pkg::CNT_W];
  assign lower_angle_limit = limits_r[apc_pkg::LIM_LOW_LO +: apc_pkg::LIM_W];
  assign upper_angle_limit = limits_r[apc_pkg::LIM_HIGH_LO +: apc_pkg::LIM_W];
  assign clamp_wrap_point = limits_r[apc_pkg::LIM_WRAP_LO +: apc_pkg::LIM_W];

  // apb phase decode
  logic setup_ph;
  logic wr_take;
  logic in_table;
  logic [11:0] tbl_off;
  logic [5:0] tbl_idx;
  assign setup_ph = psel & ~penable;
  // a write lands only at the answered access edge
  assign wr_take = psel & penable & pready_r & pwrite & ~pslverr_r;
  // table words: one aligned word per point from the base
  assign tbl_off = paddr - apc_pkg::ADDR_TABLE;
  assign tbl_idx = tbl_off[7:2];
  // misaligned or past the last point: unmapped
  assign in_table = (paddr >= apc_pkg::ADDR_TABLE) && (tbl_off[1:0] == 2'h0) &&
                    (tbl_off[11:2] < 10'(MAX_POINTS));

  // register writes, read mux, sticky flag
  always_comb begin
    ctrl_nxt = ctrl_r;
    zero_point_shift_nxt = zero_point_shift_r;
    limits_nxt = limits_r;
    angle_scale_factor_nxt = angle_scale_factor_r;
    late_angle_shift_nxt = late_angle_shift_r;
    flag_sticky_nxt = flag_sticky_r;
    prdata_nxt = 32'h00000000;
    pslverr_nxt = 1'b0;
    pready_nxt = setup_ph;
    if (wr_take) begin
      case (paddr)
        apc_pkg::ADDR_CTRL: ctrl_nxt = pwdata[13:0];
        apc_pkg::ADDR_ZERO: zero_point_shift_nxt = pwdata[14:0];
        apc_pkg::ADDR_LIMITS: limits_nxt = pwdata[23:0];
        apc_pkg::ADDR_SCALE: angle_scale_factor_nxt = pwdata[15:0];
        apc_pkg::ADDR_LATE: late_angle_shift_nxt = pwdata[15:0];
        // write one clears the flag, other status bits read only
        apc_pkg::ADDR_STATUS: begin
          if (pwdata[apc_pkg::STAT_FLAG]) begin
            flag_sticky_nxt = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // a new flag wins over a clear in the same cycle
    if (s1_valid_r && s1_flag_r) begin
      flag_sticky_nxt = 1'b1;
    end
    if (setup_ph) begin
      case (paddr)
        apc_pkg::ADDR_CTRL: prdata_nxt = {18'h00000, ctrl_r};
        apc_pkg::ADDR_ZERO: prdata_nxt = {17'h00000, zero_point_shift_r};
        apc_pkg::ADDR_LIMITS: prdata_nxt = {8'h00, limits_r};
        apc_pkg::ADDR_SCALE: prdata_nxt = {16'h0000, angle_scale_factor_r};
        apc_pkg::ADDR_LATE: prdata_nxt = {16'h0000, late_angle_shift_r};
        apc_pkg::ADDR_STATUS: prdata_nxt = {out_angle_r, 15'h0000, flag_sticky_r};
        default: begin
          if (in_table) begin
            prdata_nxt = {19'h00000, point_r[tbl_idx]};
          end else begin
            pslverr_nxt = 1'b1;
          end
        end
      endcase
      // writes answer with zero data
      if (pwrite) begin
        prdata_nxt = 32'h00000000;
      end
    end
  end

  // configuration and bus state, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= {apc_pkg::CNT_RESET, 8'h00};
      zero_point_shift_r <= 15'h0000;
      limits_r <= 24'h000000;
      angle_scale_factor_r <= apc_pkg::GAIN_RESET;
      late_angle_shift_r <= 16'h0000;
      flag_sticky_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      zero_point_shift_r <= zero_point_shift_nxt;
      limits_r <= limits_nxt;
      angle_scale_factor_r <= angle_scale_factor_nxt;
      late_angle_shift_r <= late_angle_shift_nxt;
      flag_sticky_r <= flag_sticky_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // correction point table, one register per entry
  // entries past a point count of two or more are stored but never looked up
  for (genvar g = 0; g < MAX_POINTS; g++) begin : g_pt
    logic [12:0] pt_nxt;
    assign pt_nxt = (wr_take && in_table && tbl_idx == 6'(g)) ? pwdata[12:0] : point_r[g];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        point_r[g] <= 13'h0000;
      end else if (ce) begin
        point_r[g] <= pt_nxt;
      end
    end
  end

  // stage one: zero shift, limits, gain, late shift, direction
  always_comb begin
    logic [15:0] a1;
    logic [31:0] prod;
    logic [21:0] gained;
    logic [15:0] a2;
    logic signed [17:0] late_sum;
    logic [15:0] a3;
    a2 = 16'h0000;
    a3 = 16'h0000;
    // zero shift always wraps; the limit check only flags
    a1 = angle_in + {zero_point_shift_r, 1'b0};
    // upper limit compares against the bin start, not its end
    s1_flag_nxt = limit_compare_enable &&
                  ((a1 < {lower_angle_limit, 8'h00}) || (a1 > {upper_angle_limit, 8'h00}));
    // 6.10 gain; the product keeps every integer bit
    prod = a1 * angle_scale_factor_r;
    gained = prod[31:apc_pkg::GAIN_FRAC];
    // past full scale: top code up to the wrap point, then zero
    // a wrap point below turn over gain leaves a dead zone
    if (!scale_clamp_enable || gained <= 22'(apc_pkg::ANG_MAX)) begin
      a2 = gained[15:0];
    end else if (a1 <= {clamp_wrap_point, 8'h00}) begin
      a2 = apc_pkg::ANG_MAX;
    end else begin
      a2 = 16'h0000;
    end
    // late shift counts two codes per step
    late_sum = 18'({2'b00, a2}) + 18'(signed'({late_angle_shift_r, 1'b0}));
    if (!late_shift_clamp_enable) begin
      a3 = late_sum[15:0];
    end else if (late_sum < 18'sh0) begin
      a3 = 16'h0000;
    end else if (late_sum > 18'sh0FFFF) begin
      a3 = apc_pkg::ANG_MAX;
    end else begin
      a3 = late_sum[15:0];
    end
    // inversion maps zero onto zero, never a full turn
    s1_angle_nxt = rotation_direction_invert ? (16'h0000 - a3) : a3;
    s1_valid_nxt = angle_in_valid;
  end

  // stage two: table lookup feeding the linearizer
  apc_lin_if lk ();
  logic [5:0] seg_count;
  logic [21:0] seg_pos;
  logic [5:0] seg_idx;
  // fewer than two points act as two, too many as the maximum
  assign seg_count = (point_count < apc_pkg::CNT_MIN) ? 6'h01 :
                     (point_count > 6'(MAX_POINTS)) ? 6'(MAX_POINTS - 1) : point_count - 6'h01;
  // segment index in the upper bits, fraction below
  assign seg_pos = s1_angle_r * seg_count;
  assign seg_idx = seg_pos[21:16];
  assign lk.angle = s1_angle_r;
  assign lk.mode = apc_pkg::apc_mode_t'(curve_mode);
  assign lk.range_sel = correction_range_select;
  assign lk.code_lo = signed'(point_r[seg_idx]);
  assign lk.code_hi = signed'(point_r[seg_idx + 6'h01]);
  assign lk.frac = seg_pos[15:0];

  apc_lin u_lin (
    .lk(lk.lin)
  );

  // result capture; angle and flag hold between samples
  always_comb begin
    out_angle_nxt = out_angle_r;
    out_flag_nxt = out_flag_r;
    out_valid_nxt = s1_valid_r;
    if (s1_valid_r) begin
      out_angle_nxt = lk.result;
      out_flag_nxt = s1_flag_r;
    end
  end

  // pipeline registers, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_angle_r <= 16'h0000;
      s1_valid_r <= 1'b0;
      s1_flag_r <= 1'b0;
      out_angle_r <= 16'h0000;
      out_valid_r <= 1'b0;
      out_flag_r <= 1'b0;
    end else if (ce) begin
      s1_angle_r <= s1_angle_nxt;
      s1_valid_r <= s1_valid_nxt;
      s1_flag_r <= s1_flag_nxt;
      out_angle_r <= out_angle_nxt;
      out_valid_r <= out_valid_nxt;
      out_flag_r <= out_flag_nxt;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign angle_out = out_angle_r;
  assign angle_out_valid = out_valid_r;
  assign clamp_flag = out_flag_r;
endmodule

// ==== src/apc_lin.sv ====
// fixed-segment linearizer and binning stage, combinational
`timescale 1ns/1ps
module apc_lin (
  apc_lin_if.lin lk
);
  // interpolate, scale, add and clip
  always_comb begin
    logic signed [39:0] lo_w;
    logic signed [39:0] df_w;
    logic signed [39:0] fr_w;
    logic signed [39:0] ci;
    logic signed [39:0] corr;
    logic signed [39:0] sum;
    lo_w = 40'(lk.code_lo);
    df_w = 40'(lk.code_hi) - 40'(lk.code_lo);
    fr_w = 40'({1'b0, lk.frac});
    ci = (lo_w <<< apc_pkg::FRAC_W) + df_w * fr_w;
    // negative code means positive correction
    corr = ((-ci) <<< (3'(lk.range_sel) + 3'h1)) >>> apc_pkg::FRAC_W;
    sum = 40'({24'h000000, lk.angle}) + corr;
    case (lk.mode)
      apc_pkg::APC_FIX_LIN: begin
        if (sum < 40'sh0) begin
          lk.result = 16'h0000;
        end else if (sum > 40'(apc_pkg::ANG_MAX)) begin
          lk.result = apc_pkg::ANG_MAX;
        end else begin
          lk.result = sum[15:0];
        end
      end
      apc_pkg::APC_FIX_BIN: lk.result = {lk.code_lo, 3'h0};
      default: lk.result = lk.angle; // variable-segment modes pass through
    endcase
  end
endmodule

// ==== src/apc_lin_if.sv ====
// carrier between the chain and its linearizer
`timescale 1ns/1ps
interface apc_lin_if;
  logic [15:0] angle;
  apc_pkg::apc_mode_t mode;
  logic [1:0] range_sel;
  logic signed [12:0] code_lo;
  logic signed [12:0] code_hi;
  logic [15:0] frac;
  logic [15:0] result;
  modport feed(output angle, mode, range_sel, code_lo, code_hi, frac, input result);
  modport lin(input angle, mode, range_sel, code_lo, code_hi, frac, output result);
endinterface

// ==== src/apc_pkg.sv ====
// constants and register map of the angle post-processing chain
package apc_pkg;
  localparam int ANG_W = 16;
  localparam int CODE_W = 13;
  localparam int GAIN_W = 16;
  localparam int GAIN_FRAC = 10;
  localparam int LIM_W = 8;
  localparam int ZERO_W = 15;
  localparam int CNT_W = 6;
  localparam int FRAC_W = 16;
  localparam int ADDR_W = 12;
  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_ZERO = 12'h004;
  localparam logic [11:0] ADDR_LIMITS = 12'h008;
  localparam logic [11:0] ADDR_SCALE = 12'h00C;
  localparam logic [11:0] ADDR_LATE = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  localparam logic [11:0] ADDR_TABLE = 12'h040;
  // control, limit and status field positions
  localparam int CTRL_LIMIT_EN = 0;
  localparam int CTRL_SCALE_CLAMP = 1;
  localparam int CTRL_LATE_CLAMP = 2;
  localparam int CTRL_DIR_INV = 3;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_RANGE_LO = 6;
  localparam int CTRL_CNT_LO = 8;
  localparam int LIM_LOW_LO = 0;
  localparam int LIM_HIGH_LO = 8;
  localparam int LIM_WRAP_LO = 16;
  localparam int STAT_FLAG = 0;
  localparam int STAT_ANGLE_LO = 16;
  // reset values, minimum point count and full scale
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h21;
  localparam logic [CNT_W-1:0] CNT_MIN = 6'h02;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 16'h0400;
  localparam logic [ANG_W-1:0] ANG_MAX = 16'hFFFF;
  // curve-shaping modes
  typedef enum logic [1:0] {
    APC_FIX_LIN = 2'h0,
    APC_FIX_BIN = 2'h1,
    APC_VAR_LIN = 2'h2,
    APC_VAR_BIN = 2'h3
  } apc_mode_t;
endpackage

// ==== verification/apc_chain_properties.sv ====
// port assertions for the angle chain
`timescale 1ns/1ps
module apc_chain_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] angle_in,
  input wire logic angle_in_valid,
  input wire logic [15:0] angle_out,
  input wire logic angle_out_valid,
  input wire logic clamp_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus setup and stream take
  sequence setup_s; psel && !penable && ce; endsequence
  sequence take_s; ce && angle_in_valid ##1 ce; endsequence
  out_lat_a: assert property (take_s |-> ##1 angle_out_valid) else $error("late result");
  out_src_a: assert property (angle_out_valid |-> $past(angle_in_valid, 2)) else $error("stray result");
  out_hold_a: assert property (!angle_out_valid |-> $stable(angle_out)) else $error("output moved");
  flag_hold_a: assert property (!angle_out_valid |-> $stable(clamp_flag)) else $error("flag moved");
  bus_ans_a: assert property (setup_s |=> pready) else $error("no answer");
  bus_pulse_a: assert property (pready |=> !pready) else $error("long ready");
  bus_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("lone error");
  rd_zero_a: assert property (!pready || pwrite |-> prdata == 32'h0) else $error("data leak");
endmodule
bind apc_chain apc_chain_chk i_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .angle_in(angle_in), .angle_in_valid(angle_in_valid),
  .angle_out(angle_out), .angle_out_valid(angle_out_valid), .clamp_flag(clamp_flag));

// ==== verification/apc_sink.sv ====
// downstream encoder stand-in collecting results
`timescale 1ns/1ps
module apc_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] angle_out,
  input wire logic angle_out_valid,
  input wire logic clamp_flag
);
  logic [16:0] got[$];
  // capture every result pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      got.delete();
    end else if (angle_out_valid === 1'b1) begin
      got.push_back({clamp_flag, angle_out});
    end
  end
endmodule

// ==== verification/tb_apc_chain.sv ====
// self-checking bench for the angle chain
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t %h %h", $time, a, b); end end
module tb_apc_chain;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, angle_in_valid, angle_out_valid, clamp_flag, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] angle_in, angle_out;
  int miscompares, comparisons, cyc, zr, lo, hi, wr, gn, md, rg, pts, len, sc, lc, dv;
  shortint late;
  int tbl[33];
  logic [16:0] exq[$];
  apc_chain i_apc_chain (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .angle_in(angle_in), .angle_in_valid(angle_in_valid), .angle_out(angle_out),
    .angle_out_valid(angle_out_valid), .clamp_flag(clamp_flag));
  apc_sink i_apc_sink (.pclk(pclk), .presetn(presetn), .angle_out(angle_out),
    .angle_out_valid(angle_out_valid), .clamp_flag(clamp_flag));
  // clock and hang guard
  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one apb transfer held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // expected {flag, angle} for one input
  function automatic logic [16:0] model(input int a);
    longint g, s, p, ci, o;
    int a1, ix, f;
    a1 = (a + 2 * zr) % 65536;
    f = len && (a1 < lo * 256 || a1 > hi * 256);
    g = (longint'(a1) * gn) >>> 10;
    if (!sc) g = g % 65536;
    else if (g > 65535) g = (a1 <= wr * 256) ? 65535 : 0;
    s = g + 2 * late;
    s = lc ? (s < 0 ? 0 : s > 65535 ? 65535 : s) : s & 65535;
    if (dv) s = (65536 - s) & 65535;
    p = s * (pts - 1);
    ix = int'(p >> 16);
    ci = longint'(tbl[ix]) * 65536 + longint'(tbl[ix + 1] - tbl[ix]) * (p & 65535);
    o = s + ((-ci <<< (rg + 1)) >>> 16);
    o = o < 0 ? 0 : o > 65535 ? 65535 : o;
    if (md == 1) o = (tbl[ix] & 8191) << 3;
    if (md > 1) o = s;
    return {f[0], o[15:0]};
  endfunction
  // random configuration, every mode in turn, zero gain first
  task automatic cfg(input int it);
    md = it % 4;
    rg = $urandom_range(3);
    pts = $urandom_range(33, 2);
    len = $urandom_range(1);
    sc = $urandom_range(1);
    lc = $urandom_range(1);
    dv = $urandom_range(1);
    zr = $urandom_range(32767);
    lo = $urandom_range(255);
    hi = $urandom_range(255);
    wr = $urandom_range(255);
    gn = it == 0 ? 0 : $urandom_range(65535);
    if (it % 2 == 1 && gn > 1024) wr = 128 + 131072 / gn;
    late = shortint'($urandom);
    apb(1'b1, apc_pkg::ADDR_CTRL, 32'(pts << 8 | rg << 6 | md << 4 | dv << 3 | lc << 2 | sc << 1 | len));
    apb(1'b1, apc_pkg::ADDR_ZERO, 32'(zr));
    apb(1'b1, apc_pkg::ADDR_LIMITS, 32'(wr << 16 | hi << 8 | lo));
    apb(1'b1, apc_pkg::ADDR_SCALE, 32'(gn));
    apb(1'b1, apc_pkg::ADDR_LATE, 32'(late) & 32'h0000FFFF);
    for (int i = 0; i < 33; i++) begin
      tbl[i] = $urandom_range(8191) - 4096;
      if (it % 3 == 0 && (i == 0 || i == pts - 1)) tbl[i] = 0;
      apb(1'b1, apc_pkg::ADDR_TABLE + 12'(4 * i), 32'(tbl[i]) & 32'h00001FFF);
    end
  endtask
  // back-to-back samples with end-of-circle corners, then status
  task automatic burst();
    logic [15:0] a;
    logic [16:0] e, g;
    logic f;
    f = 1'b0;
    for (int i = 0; i < 8; i++) begin
      a = i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : 16'($urandom);
      angle_in <= a;
      angle_in_valid <= 1'b1;
      exq.push_back(model(a));
      // first sample waits out two frozen cycles, taken once
      if (i == 0) begin
        ce <= 1'b0;
        repeat (2) @(posedge pclk);
        ce <= 1'b1;
      end
      @(posedge pclk);
    end
    angle_in_valid <= 1'b0;
    angle_in <= ~a;
    repeat (4) @(posedge pclk);
    `CHK(i_apc_sink.got.size(), exq.size())
    while (exq.size() > 0 && i_apc_sink.got.size() > 0) begin
      e = exq.pop_front();
      g = i_apc_sink.got.pop_front();
      f = f | e[16];
      `CHK(g, e)
    end
    apb(1'b0, apc_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd, {e[15:0], 15'h0, f})
    apb(1'b1, apc_pkg::ADDR_STATUS, 32'h1);
  endtask
  // main sequence
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    angle_in = 16'h0000;
    angle_in_valid = 1'b0;
    void'($urandom(42));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, apc_pkg::ADDR_CTRL, 32'h0);
    `CHK(rd, 32'h00002100)
    apb(1'b0, apc_pkg::ADDR_SCALE, 32'h0);
    `CHK(rd, 32'h00000400)
    apb(1'b1, 12'h020, 32'hFFFFFFFF);
    `CHK(er, 1'b1)
    apb(1'b0, 12'h020, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    for (int it = 0; it < 60; it++) begin
      cfg(it);
      burst();
    end
    close_out();
  end
endmodule
